//--- bench/tb_smbus_temp_result_access.sv
`timescale 1ns/10ps
module tb_smbus_temp_result_access;
   import tmon_pkg::*;
   localparam int unsigned HOLD = 2000; // short freeze timeout for sim
   localparam int K_WR = 0;
   localparam int K_SEND = 1;
   localparam int K_RD = 2;
   localparam int K_RECV = 3;
   logic       mclk, rst, conv_clk, conv_valid;
   tmon_conv_s conv_res, r;
   logic       smb_dat_out, smb_dat_oe, scl_oe, sda_oe;
   logic [7:0] q, lim [14];
   int         mismatches, samples_checked, seed, rnd;
   // open-drain wires with pullups
   wire        scl = !scl_oe;
   wire        sda = !(sda_oe || (smb_dat_oe && !smb_dat_out));
   tmon_smb #(.HOLD_TMO_CYC(HOLD)) dut (.mclk(mclk), .rst(rst), .smb_clk_in(scl), .smb_dat_in(sda),
      .smb_dat_out(smb_dat_out), .smb_dat_oe(smb_dat_oe), .conv_clk(conv_clk), .conv_valid(conv_valid),
      .conv_res(conv_res));
   tmon_host host (.mclk(mclk), .sda(sda), .scl_oe(scl_oe), .sda_oe(sda_oe));
   // ---------------------------------------------
   // clocks, unrelated in phase
   // ---------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = !mclk;
   end
   initial begin
      conv_clk = 1'b0;
      #1.7;
      forever #3 conv_clk = !conv_clk;
   end
   // ---------------------------------------------
   // checks and expectations
   // ---------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_byte
   task automatic cmp_ack(input string n, input logic [2:0] e, input logic [2:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask : cmp_ack
   function automatic logic [7:0] exp_main(input tmon_conv_s c);
      if (c.open) return CODE_OPEN;
      if (c.short) return CODE_SHORT;
      if (c.raw[11]) return TEMP_MIN;
      if (c.raw >= 12'd1024) return TEMP_MAX;
      return c.raw[10:3];
   endfunction : exp_main
   function automatic logic [7:0] exp_ext(input tmon_conv_s c);
      return (c.open || c.short) ? 8'h00 : {c.raw[2:0], 5'b00000};
   endfunction : exp_ext
   // writable places: alert limits, overtemp limits, config
   function automatic logic [7:0] wcmd(input int i);
      if (i < 7) return CMD_ALIM1 + 8'(i);
      if (i == 7) return CMD_OLIM1;
      if (i < 11) return CMD_OLIM4 + 8'(i - 8);
      return CMD_CFG1 + 8'(i - 11);
   endfunction : wcmd
   // one transfer, every ack the kind calls for must come
   task automatic bus(input int k, input logic [7:0] c, input logic [7:0] d, output logic [7:0] o);
      logic [2:0] a;
      host.xact(SLAVE_ADDR, k, c, d, o, a);
      cmp_ack("ack", (k == K_RECV) ? 3'b001 : (k == K_SEND) ? 3'b011 : 3'b111, a);
   endtask : bus
   task automatic conv(input tmon_conv_s c);
      @(posedge conv_clk);
      conv_valid <= 1'b1;
      conv_res <= c;
      @(posedge conv_clk);
      conv_valid <= 1'b0;
      repeat (12) @(posedge mclk); // spacing the crossing needs
   endtask : conv
   // channel 1 fraction is read first, which also freezes its main byte
   task automatic chk_conv(input tmon_conv_s c);
      conv(c);
      if (c.chan == CH1) begin
         bus(K_RD, CMD_EXT1, 8'h00, q);
         cmp_byte("ext", exp_ext(c), q);
      end
      bus(K_RD, {5'b00000, c.chan}, 8'h00, q);
      cmp_byte("main", exp_main(c), q);
   endtask : chk_conv
   // ---------------------------------------------
   // watchdog
   // ---------------------------------------------
   initial begin
      repeat (95000) @(posedge mclk);
      mismatches++;
      results();
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      seed = 69132;
      mismatches = 0;
      samples_checked = 0;
      rst = 1'b1;
      conv_valid = 1'b0;
      conv_res = '0;
      r = '0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      bus(K_RECV, 8'h00, 8'h00, q);
      cmp_byte("ptr_rst", REG_RST, q);
      for (int i = 1; i < 12; i++) begin
         bus(K_RD, (i < 9) ? 8'(i) : CMD_ST1 + 8'(i - 9), 8'h00, q);
         cmp_byte("ro_rst", REG_RST, q);
      end
      for (int i = 0; i < 14; i++) begin
         bus(K_RD, wcmd(i), 8'h00, q);
         cmp_byte("lim_rst", LIM_RST, q);
      end
      // back-to-back writes, ff to the first and random to the rest, then read all back
      for (int i = 0; i < 14; i++) begin
         rnd = $random(seed);
         lim[i] = (i == 0) ? 8'hff : 8'(rnd);
         bus(K_WR, wcmd(i), lim[i], q);
      end
      for (int i = 0; i < 14; i++) begin
         bus(K_RD, wcmd(i), 8'h00, q);
         cmp_byte("lim", lim[i], q);
      end
      // results and unmapped places ignore writes
      bus(K_WR, CMD_TEMP1, 8'h5a, q);
      bus(K_WR, 8'h30, 8'ha5, q);
      bus(K_RD, CMD_TEMP1, 8'h00, q);
      cmp_byte("ro_wr", REG_RST, q);
      bus(K_RD, 8'h30, 8'h00, q);
      cmp_byte("unmapped", 8'h00, q);
      // another address gets no ack and leaves the pointer alone
      host.xact(SLAVE_ADDR ^ 7'h01, K_RD, wcmd(2), 8'h00, q, r.chan);
      cmp_ack("wrong_addr", 3'b000, r.chan);
      cmp_byte("released", 8'hff, q);
      bus(K_RECV, 8'h00, 8'h00, q);
      cmp_byte("recv_last", 8'h00, q);
      // slow host: send byte selects, receive byte reads it
      host.hp = 20;
      bus(K_SEND, wcmd(3), 8'h00, q);
      bus(K_RECV, 8'h00, 8'h00, q);
      cmp_byte("send_recv", lim[3], q);
      host.hp = 6;
      // corner raws, then random ones
      // every channel once, so saturation and clamp reach channels 4 and local
      for (int i = 0; i < 7; i++) begin
         r = '0;
         r.chan = 3'(i + 1);
         r.raw = (i == 0) ? 12'd1023 : (i == 1) ? 12'd1024 : (i == 2) ? 12'hfff :
                 (i == 4) ? 12'd0 : (i == 6) ? 12'h800 : 12'h7ff;
         chk_conv(r);
      end
      for (int i = 0; i < 8; i++) begin
         rnd = $random(seed);
         r = '0;
         r.chan = (i == 0) ? CH1 : (i == 1) ? CH_LOCAL : 3'(1 + ($unsigned(rnd) % 7));
         rnd = $random(seed);
         r.raw = 12'(rnd);
         chk_conv(r);
      end
      // open on 3, short on 5 and then on 1, then a good 3 clears its flag
      r = '0;
      r.chan = 3'd3;
      r.open = 1'b1;
      chk_conv(r);
      bus(K_RD, CMD_ST3, 8'h00, q);
      cmp_byte("st3_open", 8'h04, q);
      bus(K_RD, CMD_ST2, 8'h00, q);
      cmp_byte("st2", 8'h00, q);
      bus(K_RD, CMD_ST1, 8'h00, q);
      cmp_byte("st1", 8'h00, q);
      r.chan = 3'd5;
      r.open = 1'b0;
      r.short = 1'b1;
      chk_conv(r);
      r.chan = CH1;
      chk_conv(r);
      r = '0;
      r.chan = 3'd3;
      r.raw = 12'd400;
      chk_conv(r);
      bus(K_RD, CMD_ST3, 8'h00, q);
      cmp_byte("st3", 8'h11, q);
      // freeze: a channel 1 result arriving before main is read is dropped; the next one lands
      r = '0;
      r.chan = CH1;
      r.raw = 12'd200;
      bus(K_RD, CMD_EXT1, 8'h00, q);
      conv(r);
      bus(K_RD, CMD_TEMP1, 8'h00, q);
      cmp_byte("frozen", exp_main('{chan: CH1, raw: 12'h0, open: 1'b0, short: 1'b1}), q);
      conv(r);
      bus(K_RD, CMD_TEMP1, 8'h00, q);
      cmp_byte("thawed", exp_main(r), q);
      // timeout: hold dropped without a main read
      bus(K_RD, CMD_EXT1, 8'h00, q);
      repeat (HOLD + 200) @(posedge mclk);
      r.raw = 12'd421;
      conv(r);
      bus(K_RD, CMD_TEMP1, 8'h00, q);
      cmp_byte("timeout", exp_main(r), q);
      results();
   end
endmodule : tb_smbus_temp_result_access

//--- bench/tmon_host.sv
`timescale 1ns/10ps
// ---------------------------------------------
// bus host model: open-drain pulls only, pullups in the bench
// ---------------------------------------------
module tmon_host (
   input  wire logic mclk,
   input  wire logic sda,
   output logic      scl_oe,
   output logic      sda_oe
);
   int hp = 6; // half bit in mclk; raise it for a slow host, keep it >= 4
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask : wt
   // data moves one cycle after the clock fall, so no false start or stop
   task automatic bit_io(input logic b, output logic r);
      wt(1);
      sda_oe <= !b;
      wt(hp);
      scl_oe <= 1'b0;
      wt(hp);
      @(negedge mclk);
      r = sda; // sampled at the end of the high phase, half a cycle before the clock is pulled low
      @(posedge mclk);
      scl_oe <= 1'b1;
   endtask : bit_io
   // start and repeated start share one sequence
   task automatic start();
      wt(1);
      sda_oe <= 1'b0;
      wt(hp);
      scl_oe <= 1'b0;
      wt(hp);
      sda_oe <= 1'b1;
      wt(hp);
      scl_oe <= 1'b1;
   endtask : start
   task automatic stop();
      wt(1);
      sda_oe <= 1'b1;
      wt(hp);
      scl_oe <= 1'b0;
      wt(hp);
      sda_oe <= 1'b0;
      wt(hp);
   endtask : stop
   // msb first, then one ack clock with data released
   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask : put
   // final read byte is never acked
   task automatic get(output logic [7:0] q);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, q[i]);
      end
      bit_io(1'b1, r);
   endtask : get
   // kinds: 0 write byte, 1 send byte, 2 read byte, 3 receive byte only
   // single master here, so the short kinds are safe to use
   task automatic xact(input logic [6:0] a, input int k, input logic [7:0] c, input logic [7:0] d,
                       output logic [7:0] q, output logic [2:0] acks);
      q = 8'h00;
      acks = 3'b000;
      start();
      if (k == 3) begin
         put({a, 1'b1}, acks[0]);
         get(q);
      end else begin
         put({a, 1'b0}, acks[0]);
         put(c, acks[1]);
         if (k == 0) begin
            put(d, acks[2]);
         end
         if (k == 2) begin
            start();
            put({a, 1'b1}, acks[2]);
            get(q);
         end
      end
      stop();
   endtask : xact
endmodule : tmon_host

//--- verilog/tmon_pkg.sv
// Behaviour
// R1 - all data visible as 8-bit registers
// R2 - one slave address reaches every register
// R3 - only write/read/send/receive byte supported
// R4 - receive byte returns last commanded register
// R5 - multi-master hosts avoid short transfer types
// R6 - channel 1 has eleven bits, eighth degree
// R7 - other channels eight bits, whole degrees
// R8 - high byte main, channel 1 fraction separate
// R9 - main byte saturates 7f, clamps 00
// R10 - fraction in bits 7:5, low bits zero
// R11 - extended read freezes channel 1 main byte
// R12 - freeze released after bus timeout 37 ms
// R13 - open diode reports ff and flags fault
// R14 - shorted diode reports ff or ee
// R15 - open fault sets status bit only
// R16 - fault result accepted, sequence moves on
// R17 - unused channel inputs left unconnected
// R18 - seven alert limit registers
// R19 - four overtemp limits for channels 1,4,5,6
// R20 - all limit registers read and write
// R21 - command byte pointer, resets to 00
// R22 - results at commands 01..07, read only
// R23 - status 3 bit per faulted remote channel
// R24 - write byte and send byte framing
// R25 - read byte framing, final byte not acked
package tmon_pkg;
   // ---------------------------------------------
   // bus address, value arbitrary
   // ---------------------------------------------
   localparam logic [6:0] SLAVE_ADDR = 7'h2a;
   // ---------------------------------------------
   // command codes
   // ---------------------------------------------
   localparam logic [7:0] CMD_TEMP1  = 8'h01;
   localparam logic [7:0] CMD_LOCAL  = 8'h07;
   localparam logic [7:0] CMD_EXT1   = 8'h08;
   localparam logic [7:0] CMD_CFG1   = 8'h41;
   localparam logic [7:0] CMD_CFG2   = 8'h42;
   localparam logic [7:0] CMD_CFG3   = 8'h43;
   localparam logic [7:0] CMD_ST1    = 8'h44;
   localparam logic [7:0] CMD_ST2    = 8'h45;
   localparam logic [7:0] CMD_ST3    = 8'h46;
   localparam logic [7:0] CMD_ALIM1  = 8'h11;
   localparam logic [7:0] CMD_ALIML  = 8'h17;
   localparam logic [7:0] CMD_OLIM1  = 8'h21;
   localparam logic [7:0] CMD_OLIM4  = 8'h24;
   localparam logic [7:0] CMD_OLIM6  = 8'h26;
   localparam logic [3:0] LIM_NONE   = 4'hf;
   // ---------------------------------------------
   // data codes and reset values
   // ---------------------------------------------
   localparam logic [7:0] REG_RST    = 8'h00;
   localparam logic [7:0] LIM_RST    = 8'h00;
   localparam logic [7:0] TEMP_MAX   = 8'h7f;
   localparam logic [7:0] TEMP_MIN   = 8'h00;
   localparam logic [7:0] CODE_OPEN  = 8'hff;
   localparam logic [7:0] CODE_SHORT = 8'hee;
   localparam int         FRAC_LSB   = 5;
   localparam logic [2:0] CH1        = 3'd1;
   localparam logic [2:0] CH_LOCAL   = 3'd7;
   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int unsigned CLK_HZ    = 20000000;
   localparam int unsigned TMO_MS    = 37;
   localparam int unsigned TMO_CYC   = CLK_HZ / 1000 * TMO_MS;
   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef struct packed {
      logic [2:0]  chan;     // 1..6 remote, 7 local
      logic [11:0] raw;      // signed, eighth degrees
      logic        open;
      logic        short;
   } tmon_conv_s;
   typedef enum logic [8:0] {
      S_IDLE  = 9'b000000001,
      S_ADDR  = 9'b000000010,
      S_AACK  = 9'b000000100,
      S_CMD   = 9'b000001000,
      S_CACK  = 9'b000010000,
      S_WDAT  = 9'b000100000,
      S_WACK  = 9'b001000000,
      S_RDAT  = 9'b010000000,
      S_RACK  = 9'b100000000
   } tmon_state_e;
endpackage : tmon_pkg

//--- verilog/tmon_smb.sv
`timescale 1ns/10ps
module tmon_smb #(
   parameter int unsigned HOLD_TMO_CYC = tmon_pkg::TMO_CYC
) (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic               smb_clk_in,
   input  wire logic               smb_dat_in,
   output logic                    smb_dat_out,
   output logic                    smb_dat_oe,
   input  wire logic               conv_clk,
   input  wire logic               conv_valid,
   input  wire tmon_pkg::tmon_conv_s conv_res
);
   import tmon_pkg::*;

   // ---------------------------------------------
   // pin synchronisers and bus events
   // ---------------------------------------------
   logic [1:0] pin_s;
   logic       scl_q, sda_q;
   tmon_sync #(.W(2)) u_pin (.clk(mclk), .d({smb_clk_in, smb_dat_in}), .q(pin_s));

   always_ff @(posedge mclk) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= pin_s[1];
         sda_q <= pin_s[0];
      end
   end

   // start/stop are data edges while the clock stays high
   wire scl_rise = pin_s[1] & ~scl_q;
   wire scl_fall = ~pin_s[1] & scl_q;
   wire start_ev = pin_s[1] & scl_q & sda_q & ~pin_s[0];
   wire stop_ev  = pin_s[1] & scl_q & ~sda_q & pin_s[0];
   wire sda      = pin_s[0];

   // ---------------------------------------------
   // register storage
   // ---------------------------------------------
   tmon_state_e st_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q, tx_q, cmd_q;
   logic        rw_q, oe_q;
   logic [7:0]  temp_q [0:6];
   logic [7:0]  ext_q, cfg1_q, cfg2_q, cfg3_q;
   logic [5:0]  st3_q;
   logic [7:0]  lim_q [0:10];
   logic        hold_q;
   logic [31:0] hold_cnt_q;

   // limit decode, shared by read and write paths
   function automatic logic [3:0] lim_idx(input logic [7:0] c);
      if (c >= CMD_ALIM1 && c <= CMD_ALIML)
         lim_idx = 4'(c - CMD_ALIM1);                      // R18
      else if (c == CMD_OLIM1)
         lim_idx = 4'd7;                                   // R19
      else if (c >= CMD_OLIM4 && c <= CMD_OLIM6)
         lim_idx = 4'(c - CMD_OLIM4 + 8'd8);               // R19
      else
         lim_idx = LIM_NONE;
   endfunction : lim_idx

   // ---------------------------------------------
   // read selection
   // ---------------------------------------------
   wire [3:0] rd_lim   = lim_idx(cmd_q);
   wire [3:0] wr_lim   = lim_idx(cmd_q);
   wire       rd_temp  = cmd_q >= CMD_TEMP1 && cmd_q <= CMD_LOCAL;
   wire [2:0] rd_tidx  = 3'(cmd_q - CMD_TEMP1);
   // status 1 and 2 belong to the alarm logic outside; they read as zero here
   wire [7:0] rd_val   = rd_temp               ? temp_q[rd_tidx] :   // R22
                         (cmd_q == CMD_EXT1)   ? ext_q :
                         (cmd_q == CMD_CFG1)   ? cfg1_q :
                         (cmd_q == CMD_CFG2)   ? cfg2_q :
                         (cmd_q == CMD_CFG3)   ? cfg3_q :
                         (cmd_q == CMD_ST3)    ? {2'b00, st3_q} :
                         (rd_lim != LIM_NONE)  ? lim_q[rd_lim] :     // R20 R1
                                                 REG_RST;
   wire [7:0] rx_byte  = {sh_q[6:0], sda};
   wire       last_bit = bit_q == 4'd7;
   wire       rd_load  = (st_q == S_AACK) && scl_fall && oe_q && rw_q;
   wire       wr_strb  = (st_q == S_WDAT) && scl_rise && last_bit;

   // ---------------------------------------------
   // bus slave state machine
   // ---------------------------------------------
   // ack phase: first fall drives low, second fall releases
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q  <= S_IDLE;
         bit_q <= 4'd0;
         sh_q  <= 8'h00;
         tx_q  <= 8'h00;
         rw_q  <= 1'b0;
         oe_q  <= 1'b0;
         cmd_q <= REG_RST;                                  // R21
      end else if (start_ev) begin
         st_q  <= S_ADDR;                                   // R25
         bit_q <= 4'd0;
         oe_q  <= 1'b0;
      end else if (stop_ev) begin
         st_q  <= S_IDLE;                                   // R24
         oe_q  <= 1'b0;
      end else begin
         case (st_q)
            S_ADDR, S_CMD, S_WDAT: begin
               if (scl_rise) begin
                  sh_q  <= rx_byte;
                  bit_q <= last_bit ? 4'd0 : bit_q + 4'd1;
                  if (last_bit && st_q == S_ADDR) begin
                     rw_q <= sda;
                     st_q <= (sh_q[6:0] == SLAVE_ADDR) ? S_AACK : S_IDLE;   // R2
                  end else if (last_bit && st_q == S_CMD) begin
                     cmd_q <= rx_byte;                       // R4
                     st_q  <= S_CACK;
                  end else if (last_bit) begin
                     st_q  <= S_WACK;
                  end
               end
            end
            S_AACK, S_CACK, S_WACK: begin
               if (scl_fall && !oe_q) begin
                  oe_q <= 1'b1;                             // R24
               end else if (scl_fall) begin
                  oe_q <= 1'b0;
                  if (st_q == S_AACK && rw_q) begin
                     // receive byte and read byte both use the stored pointer
                     tx_q <= {rd_val[6:0], 1'b0};           // R4
                     oe_q <= ~rd_val[7];
                     st_q <= S_RDAT;                        // R3
                  end else if (st_q == S_AACK) begin
                     st_q <= S_CMD;
                  end else if (st_q == S_CACK) begin
                     st_q <= S_WDAT;                        // R3
                  end else begin
                     st_q <= S_IDLE;
                  end
               end
            end
            S_RDAT: begin
               if (scl_rise) begin
                  bit_q <= last_bit ? 4'd0 : bit_q + 4'd1;
                  if (last_bit)
                     st_q <= S_RACK;
               end else if (scl_fall) begin
                  oe_q <= ~tx_q[7];
                  tx_q <= {tx_q[6:0], 1'b0};
               end
            end
            S_RACK: begin
               if (scl_fall)
                  oe_q <= 1'b0;
               // only one byte per read; the ack clock rise ends it whether the host acks or not
               if (scl_rise)
                  st_q <= S_IDLE;                           // R25
            end
            S_IDLE: begin
               oe_q <= 1'b0;
            end
            default: begin
               st_q <= S_IDLE;
               oe_q <= 1'b0;
            end
         endcase
      end
   end

   // open-drain: only ever pulls low
   always_ff @(posedge mclk) begin
      if (rst) begin
         smb_dat_out <= 1'b0;
         smb_dat_oe  <= 1'b0;
      end else begin
         smb_dat_out <= 1'b0;
         smb_dat_oe  <= oe_q;
      end
   end

   // ---------------------------------------------
   // writable registers
   // ---------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg1_q <= REG_RST;
         cfg2_q <= REG_RST;
         cfg3_q <= REG_RST;
      end else if (wr_strb) begin
         if (cmd_q == CMD_CFG1) cfg1_q <= rx_byte;
         if (cmd_q == CMD_CFG2) cfg2_q <= rx_byte;
         if (cmd_q == CMD_CFG3) cfg3_q <= rx_byte;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 11; gi++) begin : g_lim
         always_ff @(posedge mclk) begin
            if (rst)
               lim_q[gi] <= LIM_RST;
            else if (wr_strb && wr_lim == 4'(gi))
               lim_q[gi] <= rx_byte;                        // R20
         end
      end
   endgenerate

   // ---------------------------------------------
   // conversion domain capture and crossing
   // ---------------------------------------------
   // results arriving while a transfer is in flight are dropped; the
   // converter runs far slower than the handshake round trip
   tmon_conv_s cap_q;
   logic       req_q, ackc_s, rstc_s, reqm_s, ack_q;
   tmon_sync #(.W(2)) u_toc (.clk(conv_clk), .d({ack_q, rst}), .q({ackc_s, rstc_s}));
   tmon_sync #(.W(1)) u_tom (.clk(mclk), .d(req_q), .q(reqm_s));
   wire c_busy = req_q ^ ackc_s;

   always_ff @(posedge conv_clk) begin
      if (rstc_s) begin
         req_q <= 1'b0;
         cap_q <= '0;
      end else if (conv_valid && !c_busy) begin
         cap_q <= conv_res;                                 // R16
         req_q <= ~req_q;
      end
   end

   // cap_q is held stable while the toggle differs, so it is sampled directly
   wire       take    = reqm_s ^ ack_q;
   wire       neg     = cap_q.raw[11];
   wire [7:0] whole   = neg ? TEMP_MIN :                    // R9
                        cap_q.raw[10] ? TEMP_MAX :          // R9
                        {1'b0, cap_q.raw[9:3]};             // R7
   wire       fault   = cap_q.open | cap_q.short;
   wire [7:0] main_b  = cap_q.open  ? CODE_OPEN :           // R13
                        cap_q.short ? CODE_SHORT :          // R14
                        whole;
   wire       frz     = hold_q && cap_q.chan == CH1;
   wire [2:0] t_idx   = 3'(cap_q.chan - CH1);
   wire       t_ok    = take && !frz && cap_q.chan != 3'd0;

   always_ff @(posedge mclk) begin
      if (rst)
         ack_q <= 1'b0;
      else if (take)
         ack_q <= reqm_s;
   end

   // ---------------------------------------------
   // result registers
   // ---------------------------------------------
   generate
      for (gi = 0; gi < 7; gi++) begin : g_temp
         always_ff @(posedge mclk) begin
            if (rst)
               temp_q[gi] <= REG_RST;                       // R22
            else if (t_ok && t_idx == 3'(gi))
               temp_q[gi] <= main_b;                        // R8
         end
      end
   endgenerate

   // fault only lands in status 3; no alarm path is touched
   always_ff @(posedge mclk) begin
      if (rst) begin
         ext_q <= REG_RST;
         st3_q <= 6'h00;
      end else if (take) begin
         if (cap_q.chan != 3'd0 && cap_q.chan != CH_LOCAL)
            st3_q[t_idx] <= fault;                          // R23 R15
         if (cap_q.chan == CH1 && !frz)
            ext_q <= fault ? REG_RST : {cap_q.raw[2:0], 5'b00000};   // R10 R6
      end
   end

   // ---------------------------------------------
   // freeze of channel 1 main byte
   // ---------------------------------------------
   wire hold_set = rd_load && cmd_q == CMD_EXT1;
   wire hold_clr = rd_load && cmd_q == CMD_TEMP1;
   wire hold_tmo = hold_q && hold_cnt_q >= HOLD_TMO_CYC - 1;

   always_ff @(posedge mclk) begin
      if (rst) begin
         hold_q     <= 1'b0;
         hold_cnt_q <= 32'd0;
      end else if (hold_set) begin
         hold_q     <= 1'b1;                                // R11
         hold_cnt_q <= 32'd0;
      end else if (hold_clr || hold_tmo) begin
         hold_q     <= 1'b0;                                // R12
         hold_cnt_q <= 32'd0;
      end else if (hold_q) begin
         hold_cnt_q <= hold_cnt_q + 32'd1;
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   property p_cmd_rst;
      @(posedge mclk) rst |=> cmd_q == REG_RST;
   endproperty
   a_cmd_rst: assert property (p_cmd_rst) else $error("pointer not cleared");   // R21

   property p_freeze;
      @(posedge mclk) disable iff (rst) hold_q |=> $stable(temp_q[0]);
   endproperty
   a_freeze: assert property (p_freeze) else $error("held byte changed");      // R11

   property p_tmo;
      @(posedge mclk) disable iff (rst) hold_tmo && !hold_set |=> !hold_q;
   endproperty
   a_tmo: assert property (p_tmo) else $error("hold not released");            // R12

   property p_open;
      @(posedge mclk) disable iff (rst)
         t_ok && cap_q.open && t_idx == 3'd2 |=> temp_q[2] == CODE_OPEN;
   endproperty
   a_open: assert property (p_open) else $error("open code wrong");            // R13

   property p_sat;
      @(posedge mclk) disable iff (rst)
         t_ok && !fault && !neg && cap_q.raw[10] && t_idx == 3'd3 |=> temp_q[3] == TEMP_MAX;
   endproperty
   a_sat: assert property (p_sat) else $error("no saturation");                // R9

   property p_clamp;
      @(posedge mclk) disable iff (rst)
         t_ok && !fault && neg && t_idx == 3'd6 |=> temp_q[6] == TEMP_MIN;
   endproperty
   a_clamp: assert property (p_clamp) else $error("no clamp");                 // R9

   property p_st3;
      @(posedge mclk) disable iff (rst)
         take && fault && cap_q.chan == 3'd5 |=> st3_q[4] ##1 st3_q[4] || take;
   endproperty
   a_st3: assert property (p_st3) else $error("fault bit missing");            // R23

   property p_ext;
      @(posedge mclk) disable iff (rst)
         take && !frz && !fault && cap_q.chan == CH1 |=>
            ext_q[FRAC_LSB-1:0] == 5'b00000 && ext_q[7:FRAC_LSB] == $past(cap_q.raw[2:0]);
   endproperty
   a_ext: assert property (p_ext) else $error("fraction byte wrong");          // R10

   property p_ack;
      @(posedge mclk) disable iff (rst)
         st_q == S_CACK && scl_fall && !oe_q && !start_ev && !stop_ev |=> smb_dat_oe == 1'b0 ##1 smb_dat_oe;
   endproperty
   a_ack: assert property (p_ack) else $error("command not acked");            // R24
endmodule : tmon_smb

//--- verilog/tmon_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser; stage one feeds stage two only
module tmon_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk) begin
      meta_q <= d;
      q      <= meta_q;
   end
endmodule : tmon_sync
